// File: rtl/pm_pinmux.sv
// serial port pin remap and event output routing, apb slave
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module pm_pinmux (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral side, one slot per routed signal
    input wire logic [pm_pkg::NUM_SIG-1:0] sig_out,
    input wire logic [pm_pkg::NUM_SIG-1:0] sig_oe,
    output logic [pm_pkg::NUM_SIG-1:0] sig_in,
    input wire logic core_event_signal,
    // pads, ports A to E, flat index port * 16 + pin
    input wire logic [pm_pkg::NUM_PINS-1:0] pin_in,
    output logic [pm_pkg::NUM_PINS-1:0] pin_out,
    output logic [pm_pkg::NUM_PINS-1:0] pin_oe
);

    // =====================================================================
    // register state
    logic [31:0] evcr_q, evcr_d;
    logic [31:0] mapr_q, mapr_d;
    logic [31:0] ext_q [4];
    logic [31:0] ext_d [4];
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;

    pm_pkg::pm_route_t route;
    pm_pkg::pm_evt_t evt;
    pm_pkg::pm_pin_loc_t [pm_pkg::NUM_SIG-1:0] loc;

    logic setup_phase;
    logic wr_fire;
    logic addr_hit;
    logic [31:0] rd_word;

    assign route = mapr_q[pm_pkg::S3_SEL_LSB+1:pm_pkg::FW_SEL_BIT];
    assign evt = evcr_q[pm_pkg::EVT_EN_BIT:pm_pkg::EVT_PIN_LSB];

    // =====================================================================
    // apb decode
    function automatic logic [31:0] read_mux(input logic [pm_pkg::ADDR_W-1:0] a,
                                             input logic [31:0] ev, input logic [31:0] mp,
                                             input logic [31:0] e0, input logic [31:0] e1,
                                             input logic [31:0] e2, input logic [31:0] e3);
        case (a)
            pm_pkg::OFF_EVENT_OUT_CTRL: return ev;
            pm_pkg::OFF_REMAP_DEBUG_CTRL: return mp;
            pm_pkg::OFF_EXT_LINE_SEL_1: return e0;
            pm_pkg::OFF_EXT_LINE_SEL_2: return e1;
            pm_pkg::OFF_EXT_LINE_SEL_3: return e2;
            pm_pkg::OFF_EXT_LINE_SEL_4: return e3;
            default: return 32'h0000_0000;
        endcase
    endfunction : read_mux

    function automatic logic is_mapped(input logic [pm_pkg::ADDR_W-1:0] a);
        return (a == pm_pkg::OFF_EVENT_OUT_CTRL) || (a == pm_pkg::OFF_REMAP_DEBUG_CTRL) ||
               (a == pm_pkg::OFF_EXT_LINE_SEL_1) || (a == pm_pkg::OFF_EXT_LINE_SEL_2) ||
               (a == pm_pkg::OFF_EXT_LINE_SEL_3) || (a == pm_pkg::OFF_EXT_LINE_SEL_4);
    endfunction : is_mapped

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] mask);
        return (old & ~mask) | (wd & mask);
    endfunction : merge

    assign setup_phase = psel && !penable;
    // writes land on the access edge that also samples pready
    assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;
    assign addr_hit = is_mapped(paddr);
    // reserved bits are masked in the register itself, so reads show zero
    assign rd_word = read_mux(paddr, evcr_q, mapr_q, ext_q[0], ext_q[1], ext_q[2], ext_q[3]);

    always_comb begin
        evcr_d = evcr_q;
        mapr_d = mapr_q;
        ext_d = ext_q;
        // answer is prepared in the setup cycle: one access cycle, no wait states
        pready_d = setup_phase;
        pslverr_d = setup_phase && !addr_hit;
        prdata_d = prdata_q;
        if (setup_phase && !pwrite) begin
            prdata_d = rd_word;
        end
        if (wr_fire) begin
            case (paddr)
                pm_pkg::OFF_EVENT_OUT_CTRL:
                    evcr_d = merge(evcr_q, pwdata, pm_pkg::WMASK_EVENT_OUT_CTRL);
                pm_pkg::OFF_REMAP_DEBUG_CTRL:
                    mapr_d = merge(mapr_q, pwdata, pm_pkg::WMASK_REMAP_DEBUG_CTRL);
                pm_pkg::OFF_EXT_LINE_SEL_1:
                    ext_d[0] = merge(ext_q[0], pwdata, pm_pkg::WMASK_EXT_LINE_SEL);
                pm_pkg::OFF_EXT_LINE_SEL_2:
                    ext_d[1] = merge(ext_q[1], pwdata, pm_pkg::WMASK_EXT_LINE_SEL);
                pm_pkg::OFF_EXT_LINE_SEL_3:
                    ext_d[2] = merge(ext_q[2], pwdata, pm_pkg::WMASK_EXT_LINE_SEL);
                pm_pkg::OFF_EXT_LINE_SEL_4:
                    ext_d[3] = merge(ext_q[3], pwdata, pm_pkg::WMASK_EXT_LINE_SEL);
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evcr_q <= pm_pkg::RST_EVENT_OUT_CTRL;
            mapr_q <= pm_pkg::RST_REMAP_DEBUG_CTRL;
            for (int i = 0; i < 4; i++) begin
                ext_q[i] <= pm_pkg::RST_EXT_LINE_SEL;
            end
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            evcr_q <= evcr_d;
            mapr_q <= mapr_d;
            ext_q <= ext_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // =====================================================================
    // pin routing
    logic [pm_pkg::NUM_PINS-1:0] pin_s;
    logic [pm_pkg::NUM_PINS-1:0] pout_q, pout_d;
    logic [pm_pkg::NUM_PINS-1:0] poe_q, poe_d;
    logic [pm_pkg::NUM_SIG-1:0] sin_q, sin_d;
    logic evt_ok;
    logic [6:0] evt_idx;

    pm_sync #(.W(pm_pkg::NUM_PINS)) u_pin_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(pin_in),
        .q(pin_s)
    );

    pm_pin_table u_table (
        .route(route),
        .loc(loc)
    );

    // codes above port E select nothing, so F, G and H are out of reach
    assign evt_ok = evt.event_out_en && (evt.port <= pm_pkg::PORT_E);
    assign evt_idx = pm_pkg::pin_index(evt.port, evt.pin);

    always_comb begin
        logic [6:0] idx;
        idx = 7'h00;
        pout_d = '0;
        poe_d = '0;
        sin_d = '1;
        for (int i = 0; i < pm_pkg::NUM_SIG; i++) begin
            if (loc[i].valid) begin
                idx = pm_pkg::pin_index(loc[i].port, loc[i].pin);
                pout_d[idx] = sig_out[i];
                poe_d[idx] = sig_oe[i];
                sin_d[i] = pin_s[idx];
            end
        end
        // event output takes its pin over any peripheral that shares it
        if (evt_ok) begin
            pout_d[evt_idx] = core_event_signal;
            poe_d[evt_idx] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pout_q <= '0;
            poe_q <= '0;
            sin_q <= '1;
        end else begin
            pout_q <= pout_d;
            poe_q <= poe_d;
            sin_q <= sin_d;
        end
    end

    assign pin_out = pout_q;
    assign pin_oe = poe_q;
    assign sig_in = sin_q;

    // =====================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_access_s;
        psel && penable && pready;
    endsequence

    function automatic logic [6:0] at(input logic [2:0] p, input logic [3:0] n);
        return pm_pkg::pin_index(p, n);
    endfunction : at

    chk_s3_none_map: assert property (
        (route.serial3_route_sel == 2'h0) && !evt_ok
        |=> pout_q[at(pm_pkg::PORT_B, 4'hA)] == $past(sig_out[pm_pkg::SIG_S3_TX])
            && poe_q[at(pm_pkg::PORT_B, 4'hE)] == $past(sig_oe[pm_pkg::SIG_S3_RTS]))
        else $error("serial3 default pins wrong");

    chk_s3_part_map: assert property (
        (route.serial3_route_sel == 2'h1) && !evt_ok
        |=> pout_q[at(pm_pkg::PORT_C, 4'hC)] == $past(sig_out[pm_pkg::SIG_S3_CK])
            && sin_q[pm_pkg::SIG_S3_CTS])
        else $error("serial3 partial pins wrong");

    chk_s3_full_map: assert property (
        (route.serial3_route_sel == 2'h3) && !evt_ok
        |=> pout_q[at(pm_pkg::PORT_D, 4'h8)] == $past(sig_out[pm_pkg::SIG_S3_TX])
            && sin_q[pm_pkg::SIG_S3_RX] == $past(pin_s[at(pm_pkg::PORT_D, 4'h9)]))
        else $error("serial3 full pins wrong");

    chk_s2_pin_map: assert property (
        !evt_ok |=> pout_q[$past(route.serial2_route_sel) ? at(pm_pkg::PORT_D, 4'h5)
                                                           : at(pm_pkg::PORT_A, 4'h2)]
                    == $past(sig_out[pm_pkg::SIG_S2_TX]))
        else $error("serial2 tx pin wrong");

    chk_s1_pin_map: assert property (
        route.serial1_route_sel |=> sin_q[pm_pkg::SIG_S1_RX]
                                    == $past(pin_s[at(pm_pkg::PORT_B, 4'h7)]))
        else $error("serial1 rx pin wrong");

    chk_tw_pin_map: assert property (
        route.twowire_route_sel && !evt_ok
        |=> poe_q[at(pm_pkg::PORT_B, 4'h9)] == $past(sig_oe[pm_pkg::SIG_TW_SDA]))
        else $error("two-wire data pin wrong");

    chk_fw_pin_map: assert property (
        route.fourwire_route_sel && !evt_ok
        |=> pout_q[at(pm_pkg::PORT_A, 4'hF)] == $past(sig_out[pm_pkg::SIG_FW_SEL]))
        else $error("four-wire select pin wrong");

    chk_apb_answer: assert property (
        apb_setup_s ##1 psel && penable |-> pready && pslverr == !$past(addr_hit))
        else $error("apb answer not in first access cycle");

    chk_evt_reserved: assert property (
        apb_setup_s ##1 apb_access_s ##0 !pwrite && (paddr == pm_pkg::OFF_EVENT_OUT_CTRL)
        |-> prdata[31:8] == 24'h00_0000)
        else $error("reserved event bits not zero");

    chk_evt_drive: assert property (
        evt_ok |=> pout_q[$past(evt_idx)] == $past(core_event_signal) && poe_q[$past(evt_idx)])
        else $error("core event not on selected pin");

    chk_evt_no_fg: assert property (
        evt.event_out_en && (evt.port > pm_pkg::PORT_E) && !(|sig_oe) |=> !(|poe_q))
        else $error("event routed beyond port E");

    chk_reset_home: assert property (disable iff (1'b0)
        $rose(presetn) |-> !evt_ok && route == '0 && evcr_q == '0)
        else $error("routing not at defaults after reset");

endmodule : pm_pinmux

// File: rtl/pm_pkg.sv
// package for the serial pin remap and event output routing block
package pm_pkg;

    // =====================================================================
    // geometry
    localparam int NUM_PORTS = 5;
    localparam int PINS_PER_PORT = 16;
    localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;
    localparam int NUM_SIG = 18;
    localparam int ADDR_W = 12;

    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;

    // =====================================================================
    // register map
    localparam logic [31:0] PINMUX_BASE = 32'h4001_0000;
    localparam logic [ADDR_W-1:0] OFF_EVENT_OUT_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_REMAP_DEBUG_CTRL = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_EXT_LINE_SEL_1 = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_EXT_LINE_SEL_2 = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_EXT_LINE_SEL_3 = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_EXT_LINE_SEL_4 = 12'h014;

    localparam logic [31:0] RST_EVENT_OUT_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_REMAP_DEBUG_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_EXT_LINE_SEL = 32'h0000_0000;

    // writable bits; everything else reads back zero
    localparam logic [31:0] WMASK_EVENT_OUT_CTRL = 32'h0000_00FF;
    localparam logic [31:0] WMASK_REMAP_DEBUG_CTRL = 32'hE01F_FFFF;
    localparam logic [31:0] WMASK_EXT_LINE_SEL = 32'hFFFF_FFFF;

    // =====================================================================
    // field positions
    localparam int EVT_EN_BIT = 7;
    localparam int EVT_PORT_LSB = 4;
    localparam int EVT_PIN_LSB = 0;
    localparam int S3_SEL_LSB = 4;
    localparam int S2_SEL_BIT = 3;
    localparam int S1_SEL_BIT = 2;
    localparam int TW_SEL_BIT = 1;
    localparam int FW_SEL_BIT = 0;

    localparam logic [1:0] S3_ROUTE_NONE = 2'h0;
    localparam logic [1:0] S3_ROUTE_PART = 2'h1;
    localparam logic [1:0] S3_ROUTE_FULL = 2'h3;

    // =====================================================================
    // peripheral signal slots
    localparam int SIG_S3_TX = 0;
    localparam int SIG_S3_RX = 1;
    localparam int SIG_S3_CK = 2;
    localparam int SIG_S3_CTS = 3;
    localparam int SIG_S3_RTS = 4;
    localparam int SIG_S2_CTS = 5;
    localparam int SIG_S2_RTS = 6;
    localparam int SIG_S2_TX = 7;
    localparam int SIG_S2_RX = 8;
    localparam int SIG_S2_CK = 9;
    localparam int SIG_S1_TX = 10;
    localparam int SIG_S1_RX = 11;
    localparam int SIG_TW_SCL = 12;
    localparam int SIG_TW_SDA = 13;
    localparam int SIG_FW_SEL = 14;
    localparam int SIG_FW_SCK = 15;
    localparam int SIG_FW_MISO = 16;
    localparam int SIG_FW_MOSI = 17;

    // =====================================================================
    // types
    typedef struct packed {
        logic valid;
        logic [2:0] port;
        logic [3:0] pin;
    } pm_pin_loc_t;

    typedef struct packed {
        logic [1:0] serial3_route_sel;
        logic serial2_route_sel;
        logic serial1_route_sel;
        logic twowire_route_sel;
        logic fourwire_route_sel;
    } pm_route_t;

    typedef struct packed {
        logic event_out_en;
        logic [2:0] port;
        logic [3:0] pin;
    } pm_evt_t;

    function automatic pm_pin_loc_t pin_at(input logic [2:0] port, input logic [3:0] pin);
        pm_pin_loc_t l;
        l.valid = 1'b1;
        l.port = port;
        l.pin = pin;
        return l;
    endfunction : pin_at

    // flat pin number is port * 16 + pin
    function automatic logic [6:0] pin_index(input logic [2:0] port, input logic [3:0] pin);
        return {port, pin};
    endfunction : pin_index

endpackage : pm_pkg

// File: rtl/pm_sync.sv
// two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps
module pm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // meta_q feeds nothing but q
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : pm_sync

// File: rtl/pm_pin_table.sv
// pin location table for every routed peripheral signal
`timescale 1ns/1ps
module pm_pin_table (
    // routing selections
    input pm_pkg::pm_route_t route,
    // one location per signal slot
    output pm_pkg::pm_pin_loc_t [pm_pkg::NUM_SIG-1:0] loc
);
    always_comb begin
        loc = '0;
        case (route.serial3_route_sel)
            pm_pkg::S3_ROUTE_NONE: begin
                loc[pm_pkg::SIG_S3_TX] = pm_pkg::pin_at(pm_pkg::PORT_B, 4'hA);
                loc[pm_pkg::SIG_S3_RX] = pm_pkg::pin_at(pm_pkg::PORT_B, 4'hB);
                loc[pm_pkg::SIG_S3_CK] = pm_pkg::pin_at(pm_pkg::PORT_B, 4'hC);
                loc[pm_pkg::SIG_S3_CTS] = pm_pkg::pin_at(pm_pkg::PORT_B, 4'hD);
                loc[pm_pkg::SIG_S3_RTS] = pm_pkg::pin_at(pm_pkg::PORT_B, 4'hE);
            end
            pm_pkg::S3_ROUTE_PART: begin
                // flow control has no pins in this setting
                loc[pm_pkg::SIG_S3_TX] = pm_pkg::pin_at(pm_pkg::PORT_C, 4'hA);
                loc[pm_pkg::SIG_S3_RX] = pm_pkg::pin_at(pm_pkg::PORT_C, 4'hB);
                loc[pm_pkg::SIG_S3_CK] = pm_pkg::pin_at(pm_pkg::PORT_C, 4'hC);
            end
            pm_pkg::S3_ROUTE_FULL: begin
                loc[pm_pkg::SIG_S3_TX] = pm_pkg::pin_at(pm_pkg::PORT_D, 4'h8);
                loc[pm_pkg::SIG_S3_RX] = pm_pkg::pin_at(pm_pkg::PORT_D, 4'h9);
                loc[pm_pkg::SIG_S3_CK] = pm_pkg::pin_at(pm_pkg::PORT_D, 4'hA);
                loc[pm_pkg::SIG_S3_CTS] = pm_pkg::pin_at(pm_pkg::PORT_D, 4'hB);
                loc[pm_pkg::SIG_S3_RTS] = pm_pkg::pin_at(pm_pkg::PORT_D, 4'hC);
            end
            default: begin
                // code 10 is undefined: the transceiver stays off the pads
            end
        endcase
        loc[pm_pkg::SIG_S2_CTS] = pm_pkg::pin_at(route.serial2_route_sel ? pm_pkg::PORT_D
                                                 : pm_pkg::PORT_A,
                                                 route.serial2_route_sel ? 4'h3 : 4'h0);
        loc[pm_pkg::SIG_S2_RTS] = pm_pkg::pin_at(route.serial2_route_sel ? pm_pkg::PORT_D
                                                 : pm_pkg::PORT_A,
                                                 route.serial2_route_sel ? 4'h4 : 4'h1);
        loc[pm_pkg::SIG_S2_TX] = pm_pkg::pin_at(route.serial2_route_sel ? pm_pkg::PORT_D
                                                : pm_pkg::PORT_A,
                                                route.serial2_route_sel ? 4'h5 : 4'h2);
        loc[pm_pkg::SIG_S2_RX] = pm_pkg::pin_at(route.serial2_route_sel ? pm_pkg::PORT_D
                                                : pm_pkg::PORT_A,
                                                route.serial2_route_sel ? 4'h6 : 4'h3);
        loc[pm_pkg::SIG_S2_CK] = pm_pkg::pin_at(route.serial2_route_sel ? pm_pkg::PORT_D
                                                : pm_pkg::PORT_A,
                                                route.serial2_route_sel ? 4'h7 : 4'h4);
        loc[pm_pkg::SIG_S1_TX] = route.serial1_route_sel ? pm_pkg::pin_at(pm_pkg::PORT_B, 4'h6)
                                 : pm_pkg::pin_at(pm_pkg::PORT_A, 4'h9);
        loc[pm_pkg::SIG_S1_RX] = route.serial1_route_sel ? pm_pkg::pin_at(pm_pkg::PORT_B, 4'h7)
                                 : pm_pkg::pin_at(pm_pkg::PORT_A, 4'hA);
        loc[pm_pkg::SIG_TW_SCL] = pm_pkg::pin_at(pm_pkg::PORT_B,
                                                 route.twowire_route_sel ? 4'h8 : 4'h6);
        loc[pm_pkg::SIG_TW_SDA] = pm_pkg::pin_at(pm_pkg::PORT_B,
                                                 route.twowire_route_sel ? 4'h9 : 4'h7);
        loc[pm_pkg::SIG_FW_SEL] = route.fourwire_route_sel ? pm_pkg::pin_at(pm_pkg::PORT_A, 4'hF)
                                  : pm_pkg::pin_at(pm_pkg::PORT_A, 4'h4);
        loc[pm_pkg::SIG_FW_SCK] = route.fourwire_route_sel ? pm_pkg::pin_at(pm_pkg::PORT_B, 4'h3)
                                  : pm_pkg::pin_at(pm_pkg::PORT_A, 4'h5);
        loc[pm_pkg::SIG_FW_MISO] = route.fourwire_route_sel ? pm_pkg::pin_at(pm_pkg::PORT_B, 4'h4)
                                   : pm_pkg::pin_at(pm_pkg::PORT_A, 4'h6);
        loc[pm_pkg::SIG_FW_MOSI] = route.fourwire_route_sel ? pm_pkg::pin_at(pm_pkg::PORT_B, 4'h5)
                                   : pm_pkg::pin_at(pm_pkg::PORT_A, 4'h7);
    end
endmodule : pm_pin_table

// File: testbench/pm_pad_model.sv
// pad and peripheral far-side model: driven pads loop back, idle pads follow the bench
`timescale 1ns/1ps
module pm_pad_model (
    // pads
    input wire logic [pm_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [pm_pkg::NUM_PINS-1:0] pin_oe,
    output logic [pm_pkg::NUM_PINS-1:0] pin_in,
    // level the bench puts on undriven pads
    input wire logic [pm_pkg::NUM_PINS-1:0] ext_lvl
);
    // a driven pad reads back its own value, an idle one shows the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : pm_pad_model

// File: testbench/test_pm_pinmux.sv
// self-checking bench for the pin remap and event routing block
`timescale 1ns/1ps
module test_pm_pinmux;
    // =====================================================================
    // signals
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, core_ev = 1'b0;
    logic [17:0] sig_out = 18'h0, sig_oe = 18'h0, sig_in;
    logic [79:0] pin_in, pin_out, pin_oe, ext_lvl = '1;
    int n_fail = 0, total_checks = 0, cyc = 0;
    always #2 pclk = ~pclk;
    pm_pinmux DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sig_out(sig_out), .sig_oe(sig_oe), .sig_in(sig_in),
        .core_event_signal(core_ev), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pm_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_lvl(ext_lvl));
    // =====================================================================
    // tasks
    task test_done;
        if (n_fail == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // one idle edge so a following call never re-raises psel in the same step
        @(posedge pclk);
    endtask : apb
    // drive one slot out through its routed pad, then read the pad back into the slot
    task route_chk(input logic [7:0] mapr, input int slot, input int idx);
        apb(1'b1, 12'h004, {24'h0, mapr});
        sig_out <= 18'h1 << slot; sig_oe <= 18'h1 << slot; ext_lvl <= '1;
        repeat (3) @(posedge pclk);
        chk(32'(pin_out[idx]), 32'h1);
        chk(32'(pin_oe[idx]), 32'h1);
        sig_out <= 18'h0; sig_oe <= 18'h0; ext_lvl <= ~(80'h1 << idx);
        repeat (5) @(posedge pclk);
        chk(32'(sig_in[slot]), 32'h0);
        ext_lvl <= '1;
    endtask : route_chk
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            test_done;
        end
    end
    // =====================================================================
    // tests
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'(|pin_oe), 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, 32'h0);
            chk(32'(er), 32'h0);
        end
        route_chk(8'h00, 0, 26);
        route_chk(8'h00, 4, 30);
        route_chk(8'h10, 0, 42);
        route_chk(8'h10, 2, 44);
        route_chk(8'h30, 0, 56);
        route_chk(8'h30, 4, 60);
        route_chk(8'h00, 5, 0);
        route_chk(8'h08, 5, 51);
        route_chk(8'h08, 9, 55);
        route_chk(8'h00, 10, 9);
        route_chk(8'h06, 11, 23);
        route_chk(8'h00, 12, 22);
        route_chk(8'h02, 13, 25);
        route_chk(8'h00, 14, 4);
        route_chk(8'h01, 14, 15);
        route_chk(8'h01, 17, 21);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'hFFFF_FFFF);
        apb(1'b0, 12'h018, 32'h0);
        chk(32'(er), 32'h1);
        // reserved bits written high must read back zero; enable stays clear
        apb(1'b1, 12'h000, 32'hFFFF_FF25);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0025);
        repeat (2) @(posedge pclk);
        chk(32'(|pin_oe), 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h000, {24'h0, 1'b1, 3'(i < 5 ? i : 4), 4'(i < 5 ? i * 3 : 15)});
            core_ev <= 1'b1;
            repeat (3) @(posedge pclk);
            chk(32'(pin_out[(i < 5 ? i : 4) * 16 + (i < 5 ? i * 3 : 15)]), 32'h1);
            chk(32'(pin_oe[(i < 5 ? i : 4) * 16 + (i < 5 ? i * 3 : 15)]), 32'h1);
            core_ev <= 1'b0;
            repeat (3) @(posedge pclk);
            chk(32'(pin_out[(i < 5 ? i : 4) * 16 + (i < 5 ? i * 3 : 15)]), 32'h0);
        end
        for (int p = 5; p < 8; p++) begin
            apb(1'b1, 12'h000, {24'h0, 1'b1, 3'(p), 4'h2});
            repeat (3) @(posedge pclk);
            chk(32'(|pin_oe), 32'h0);
        end
        test_done;
    end
endmodule : test_pm_pinmux
